// *** hdl/tdm_defs.svh ***
// Constants of the TDM backplane port and its framer end
// What this block does
// - T1 frame: 24 slots plus framing bit
// - E1 frame: 32 slots, 256 bits, no framing bit
// - One sample per slot every frame
// - Slot byte is a compressed linear sample
// - Separate frame sync marks every frame start
// - Mapped T1 slots 24-31 accepted as dummy
// - Transmit 32 slots; framer drops 24-31 in T1
// - One bit clock, one frame sync, all lines
// - Selectable edges and frame sync delay
// - Memory interleaves receive and send lines per slot
// - Block of frames_per_block frames, default 40
// - Receive ping-pong between two buffer halves
// - Transmit uses the same ping-pong scheme
// - Optional hardware a-law or mu-law companding
// - Companding round trip may differ by one bit
// - Pass-through copies inputs to outputs unaltered
// - Double buffering adds whole-block latency
// - Framer carries payload slots only to the line; all 32 slots to the port
// - Framer may raise interrupt on line errors
// - Port makes frame sync; bit clock external
// - 32 slots at 2.048 MHz, 24 native T1
`ifndef TDM_DEFS_SVH
`define TDM_DEFS_SVH
`define T1_SLOTS 5'd24
`define E1_SLOTS 6'd32
`define T1_LAST_BIT 9'd192
`define E1_LAST_BIT 9'd255
`define FRAME_BITS 6
`define FPB_RESET 6'd40
`define CTRL_OFS 15'h0000
`define BLOCK_OFS 15'h0004
`define STATUS_OFS 15'h0008
`define REG_SEL 3'h0
`define RXWIN_SEL 3'h1
`define TXWIN_SEL 3'h2
`define CTRL_RESET 9'h020
`define C_ENABLE 0
`define C_FMT 2:1
`define C_RX_RISE 3
`define C_TX_FALL 4
`define C_FS_EARLY 5
`define C_COMPAND 6
`define C_ALAW 7
`define C_PASS 8
`endif

// *** hdl/tdm_pkg.sv ***
// Types and companding helpers of the TDM backplane port
package tdm_pkg;
	typedef enum logic [1:0] {FMT_E1, FMT_T1_MAP, FMT_T1_NATIVE, FMT_RSVD} fmt_t;
	typedef enum logic {ST_IDLE, ST_RUN} run_t;

	// Byte to 16-bit signed linear sample
	function automatic logic [15:0] expand(input logic [7:0] c, input logic alaw);
		logic [7:0] x;
		logic [15:0] m;
		x = alaw ? (c ^ 8'h55) : ~c;
		if (alaw)
			m = (x[6:4] == 3'h0) ? {11'h0, x[3:0], 1'b1} :
				(16'({1'b1, x[3:0], 1'b1}) << (x[6:4] - 3'h1));
		else
			m = (16'({x[3:0], 1'b1}) + 16'h0020 << x[6:4]) - 16'h0021;
		expand = (x[7] ^ alaw) ? -m : m;
	endfunction : expand

	// 16-bit signed linear sample to byte
	function automatic logic [7:0] compress(input logic [15:0] s, input logic alaw);
		logic [15:0] m;
		logic [2:0] e;
		logic [7:0] c;
		m = s[15] ? -s : s;
		e = 3'h0;
		if (alaw)
		begin
			if (m > 16'h0fff)
				m = 16'h0fff;
			for (int i = 5; i <= 11; i++)
				if (m[i])
					e = 3'(i - 4);
			c = {~s[15], e, (e == 3'h0) ? m[4:1] : 4'(m >> e)};
			compress = c ^ 8'h55;
		end
		else
		begin
			if (m > 16'h1fde)
				m = 16'h1fde;
			m = m + 16'h0021;
			for (int i = 6; i <= 12; i++)
				if (m[i])
					e = 3'(i - 5);
			c = {s[15], e, 4'(m >> (e + 3'h1))};
			compress = ~c;
		end
	endfunction : compress
endpackage : tdm_pkg

// *** hdl/tdm_link_if.sv ***
// Backplane wires between the port and the two framers
`timescale 1ns/1ps
interface tdm_link_if;
	logic bclk;
	logic fsync;
	logic rx_line;
	logic sx_line;
	logic rout_line;
	logic sout_line;
	modport port (input bclk, input rx_line, input sx_line,
		output fsync, output rout_line, output sout_line);
	modport framer (input bclk, input fsync, input rout_line, input sout_line,
		output rx_line, output sx_line);
endinterface : tdm_link_if

// *** hdl/serial_tdm_port.sv ***
// Device end: TDM serial port with ping-pong buffers and APB registers
`timescale 1ns/1ps
`include "tdm_defs.svh"
module serial_tdm_port #(
	parameter int FB = `FRAME_BITS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Backplane
	tdm_link_if.port link,
	// Block events
	output logic rx_block,
	output logic rx_block_half,
	output logic tx_block,
	output logic tx_block_half
);
	import tdm_pkg::*;
	localparam int AW = FB + 7;

	logic [8:0] ctrl_q;
	logic [FB-1:0] fpb_q;
	logic [7:0] rx_mem [0:(1<<AW)-1];
	logic [7:0] tx_mem [0:(1<<AW)-1];
	logic [3:0] s1_q, s2_q;
	logic bclk_prev_q;
	run_t run_q;
	logic [8:0] pos_q, pos_d, last;
	logic [7:0] pay, pay_d;
	logic fbit, fsync_q, rout_q, sout_q;
	logic [7:0] tsh_q [2];
	logic [6:0] rsh_q [2];
	logic [FB-1:0] rx_frame_q, tx_frame_q, tf_n;
	logic rx_half_q, tx_half_q, th_n, tx_wrap;
	logic rxb_q, rxh_q, txb_q, txh_q;
	logic rise, fall, smp, drv;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, access;
	fmt_t fmt;
	logic [AW-1:0] widx;
	logic [15:0] lin;

	assign fmt = fmt_t'(ctrl_q[`C_FMT]);
	assign fbit = (fmt == FMT_T1_NATIVE);
	assign lin = expand(rx_mem[paddr[AW+1:2]], ctrl_q[`C_ALAW]);
	// Native T1 has 193 bit times, otherwise 32 slots on 2.048 MHz
	assign last = fbit ? `T1_LAST_BIT : `E1_LAST_BIT;
	assign pay = 8'(pos_q - {8'h0, fbit});
	assign pos_d = (pos_q == last) ? 9'h000 : pos_q + 9'h001;
	assign pay_d = 8'(pos_d - {8'h0, fbit});

	// Bit clock and both receive lines through two flops each
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			bclk_prev_q <= 1'b0;
		end
		else
		begin
			s1_q <= {link.bclk, link.rx_line, link.sx_line, 1'b0};
			s2_q <= s1_q;
			bclk_prev_q <= s2_q[3];
		end

	assign rise = s2_q[3] & ~bclk_prev_q;
	assign fall = ~s2_q[3] & bclk_prev_q;
	assign smp = (run_q == ST_RUN) & (ctrl_q[`C_RX_RISE] ? rise : fall);
	assign drv = (run_q == ST_RUN) & (ctrl_q[`C_TX_FALL] ? fall : rise);
	assign access = psel & penable & ~pready_q;

	// Start at a frame boundary, stop at once
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			run_q <= ST_IDLE;
		else
			case (run_q)
				ST_IDLE: if (ctrl_q[`C_ENABLE])
					run_q <= ST_RUN;
				ST_RUN: if (!ctrl_q[`C_ENABLE])
					run_q <= ST_IDLE;
				default: run_q <= ST_IDLE;
			endcase

	// Transmit frame and half that the next drive position belongs to
	assign tx_wrap = (pos_d == 9'h000);
	always_comb
	begin
		tf_n = tx_frame_q;
		th_n = tx_half_q;
		if (tx_wrap)
		begin
			tf_n = (tx_frame_q >= fpb_q - 1'b1) ? '0 : tx_frame_q + 1'b1;
			th_n = (tx_frame_q >= fpb_q - 1'b1) ? ~tx_half_q : tx_half_q;
		end
	end

	// Drive side: position count, frame sync and both output lines
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pos_q <= `E1_LAST_BIT - 9'h001;
			fsync_q <= 1'b0;
			rout_q <= 1'b0;
			sout_q <= 1'b0;
			tsh_q[0] <= 8'h00;
			tsh_q[1] <= 8'h00;
			tx_frame_q <= '0;
			tx_half_q <= 1'b0;
			txb_q <= 1'b0;
			txh_q <= 1'b0;
		end
		else
		begin
			txb_q <= 1'b0;
			if (run_q == ST_IDLE)
			begin
				// One before last, so the first frame gets its sync
				pos_q <= last - 9'h001;
				fsync_q <= 1'b0;
				rout_q <= 1'b0;
				sout_q <= 1'b0;
			end
			else if (drv)
			begin
				pos_q <= pos_d;
				// Sync in the bit before bit 0, or with bit 0
				fsync_q <= ctrl_q[`C_FS_EARLY] ? (pos_d == last) : tx_wrap;
				tx_frame_q <= tf_n;
				tx_half_q <= th_n;
				if (tx_wrap && th_n != tx_half_q)
				begin
					txb_q <= 1'b1;
					txh_q <= tx_half_q;
				end
				if (fbit && pos_d == 9'h000)
				begin
					rout_q <= 1'b0;
					sout_q <= 1'b0;
				end
				else if (pay_d[2:0] == 3'h0)
				begin
					// All 32 slots sent on a 2.048 MHz backplane
					tsh_q[0] <= tx_mem[{th_n, tf_n, pay_d[7:3], 1'b0}];
					tsh_q[1] <= tx_mem[{th_n, tf_n, pay_d[7:3], 1'b1}];
					rout_q <= tx_mem[{th_n, tf_n, pay_d[7:3], 1'b0}][7];
					sout_q <= tx_mem[{th_n, tf_n, pay_d[7:3], 1'b1}][7];
				end
				else
				begin
					tsh_q[0] <= tsh_q[0] << 1;
					tsh_q[1] <= tsh_q[1] << 1;
					rout_q <= tsh_q[0][6];
					sout_q <= tsh_q[1][6];
				end
			end
		end

	// Receive side: shift, frame count and block ping-pong
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			rsh_q[0] <= 7'h00;
			rsh_q[1] <= 7'h00;
			rx_frame_q <= '0;
			rx_half_q <= 1'b0;
			rxb_q <= 1'b0;
			rxh_q <= 1'b0;
		end
		else
		begin
			rxb_q <= 1'b0;
			if (smp)
			begin
				rsh_q[0] <= {rsh_q[0][5:0], s2_q[2]};
				rsh_q[1] <= {rsh_q[1][5:0], s2_q[1]};
				if (pos_q == last)
				begin
					if (rx_frame_q >= fpb_q - 1'b1)
					begin
						rx_frame_q <= '0;
						rx_half_q <= ~rx_half_q;
						rxb_q <= 1'b1;
						rxh_q <= rx_half_q;
					end
					else
						rx_frame_q <= rx_frame_q + 1'b1;
				end
			end
		end

	// Receive memory, slot bytes interleaved by line
	assign widx = {rx_half_q, rx_frame_q, pay[7:3], 1'b0};
	always_ff @(posedge pclk)
		if (smp && !(fbit && pos_q == 9'h000) && pay[2:0] == 3'h7)
		begin
			// Mapped T1 slots 24-31 stored like any other
			rx_mem[widx] <= {rsh_q[0], s2_q[2]};
			rx_mem[{widx[AW-1:1], 1'b1}] <= {rsh_q[1], s2_q[1]};
		end

	// Transmit memory: APB writes and pass-through copies
	always_ff @(posedge pclk)
		if (access && pwrite && paddr[17:15] == `TXWIN_SEL)
			tx_mem[paddr[AW+1:2]] <= ctrl_q[`C_COMPAND] ?
				compress(pwdata[15:0], ctrl_q[`C_ALAW]) : pwdata[7:0];
		else if (ctrl_q[`C_PASS] && smp && !(fbit && pos_q == 9'h000) && pay[2:0] == 3'h7)
		begin
			// Copied into the half played next block
			tx_mem[{~tx_half_q, rx_frame_q, pay[7:3], 1'b0}] <= {rsh_q[0], s2_q[2]};
			tx_mem[{~tx_half_q, rx_frame_q, pay[7:3], 1'b1}] <= {rsh_q[1], s2_q[1]};
		end

	// Control registers
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_q <= `CTRL_RESET;
			fpb_q <= FB'(`FPB_RESET);
		end
		else if (access && pwrite && paddr[17:15] == `REG_SEL)
		begin
			if (paddr[14:0] == `CTRL_OFS)
				ctrl_q <= pwdata[8:0];
			if (paddr[14:0] == `BLOCK_OFS)
				fpb_q <= (pwdata[FB-1:0] == '0) ? FB'(1) : pwdata[FB-1:0];
		end

	// APB answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= access;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			if (access)
				case (paddr[17:15])
					`REG_SEL:
						case (paddr[14:0])
							`CTRL_OFS: prdata_q <= {23'h0, ctrl_q};
							`BLOCK_OFS: prdata_q <= 32'(fpb_q);
							`STATUS_OFS: prdata_q <= {16'h0, rx_half_q, tx_half_q,
								run_q == ST_RUN, 1'b0, 6'(rx_frame_q), 6'(tx_frame_q)};
							default: pslverr_q <= 1'b1;
						endcase
					`RXWIN_SEL: prdata_q <= ctrl_q[`C_COMPAND] ? {{16{lin[15]}}, lin} :
						{24'h0, rx_mem[paddr[AW+1:2]]};
					`TXWIN_SEL: prdata_q <= {24'h0, tx_mem[paddr[AW+1:2]]};
					default: pslverr_q <= 1'b1;
				endcase
		end

	// All four lines share this sync and the one bit clock
	assign link.fsync = fsync_q;
	assign link.rout_line = rout_q;
	assign link.sout_line = sout_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rx_block = rxb_q;
	assign rx_block_half = rxh_q;
	assign tx_block = txb_q;
	assign tx_block_half = txh_q;
endmodule : serial_tdm_port

// *** hdl/framer_pair_end.sv ***
// Far end: two line framers sharing bit clock and frame sync
`timescale 1ns/1ps
`include "tdm_defs.svh"
module framer_pair_end (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Backplane
	tdm_link_if.framer link,
	// Line side: payload only out, bytes taken for all 32 slots
	input wire logic t1_mode,
	input wire logic [7:0] rin_byte,
	input wire logic [7:0] sin_byte,
	output logic take,
	output logic [4:0] take_slot,
	output logic [7:0] rout_byte,
	output logic [7:0] sout_byte,
	output logic out_valid,
	output logic [4:0] out_slot,
	// Error interrupt
	input wire logic line_err,
	input wire logic irq_en,
	output logic irq
);
	import tdm_pkg::*;
	logic [3:0] s1_q, s2_q;
	logic prev_q;
	logic [7:0] nxt_q, cur_q;
	logic [7:0] sh_r_q, sh_s_q, in_r_q, in_s_q;
	logic rx_q, sx_q, take_q, ov_q, irq_q;
	logic [4:0] ts_q, os_q;
	logic [7:0] rb_q, sb_q;
	logic rise, fall;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			prev_q <= 1'b0;
		end
		else
		begin
			s1_q <= {link.bclk, link.fsync, link.rout_line, link.sout_line};
			s2_q <= s1_q;
			prev_q <= s2_q[3];
		end
	assign rise = s2_q[3] & ~prev_q;
	assign fall = ~s2_q[3] & prev_q;

	// Drive on rising edge, sample and find sync on falling edge
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			nxt_q <= 8'h00;
			cur_q <= 8'h00;
			sh_r_q <= 8'h00;
			sh_s_q <= 8'h00;
			in_r_q <= 8'h00;
			in_s_q <= 8'h00;
			rx_q <= 1'b0;
			sx_q <= 1'b0;
			take_q <= 1'b0;
			ts_q <= 5'h00;
			ov_q <= 1'b0;
			os_q <= 5'h00;
			rb_q <= 8'h00;
			sb_q <= 8'h00;
		end
		else
		begin
			take_q <= 1'b0;
			ov_q <= 1'b0;
			if (rise)
			begin
				cur_q <= nxt_q;
				nxt_q <= nxt_q + 8'h01;
				if (nxt_q[2:0] == 3'h0)
				begin
					// Every slot byte leaves the framer, mapped T1 slots 24-31 too
					sh_r_q <= {rin_byte[6:0], 1'b0};
					sh_s_q <= {sin_byte[6:0], 1'b0};
					rx_q <= rin_byte[7];
					sx_q <= sin_byte[7];
					take_q <= 1'b1;
					ts_q <= nxt_q[7:3];
				end
				else
				begin
					sh_r_q <= sh_r_q << 1;
					sh_s_q <= sh_s_q << 1;
					rx_q <= sh_r_q[7];
					sx_q <= sh_s_q[7];
				end
			end
			else if (fall)
			begin
				in_r_q <= {in_r_q[6:0], s2_q[1]};
				in_s_q <= {in_s_q[6:0], s2_q[0]};
				// Sync seen in the bit before bit 0
				if (s2_q[2])
					nxt_q <= 8'h00;
				// Mapped T1 drops slots 24-31
				if (cur_q[2:0] == 3'h7 && !(t1_mode && cur_q[7:3] >= `T1_SLOTS))
				begin
					ov_q <= 1'b1;
					os_q <= cur_q[7:3];
					rb_q <= {in_r_q[6:0], s2_q[1]};
					sb_q <= {in_s_q[6:0], s2_q[0]};
				end
			end
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= line_err & irq_en;

	assign link.rx_line = rx_q;
	assign link.sx_line = sx_q;
	assign take = take_q;
	assign take_slot = ts_q;
	assign rout_byte = rb_q;
	assign sout_byte = sb_q;
	assign out_valid = ov_q;
	assign out_slot = os_q;
	assign irq = irq_q;
endmodule : framer_pair_end

// *** verif/tdm_link_props.sv ***
// Assertions on the backplane wires and block events
`timescale 1ns/1ps
module tdm_link_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Backplane
	input wire logic bclk,
	input wire logic fsync,
	input wire logic rx_line,
	input wire logic sx_line,
	input wire logic rout_line,
	input wire logic sout_line,
	// Block events
	input wire logic rx_block,
	input wire logic rx_block_half,
	input wire logic tx_block,
	input wire logic tx_block_half
);
	localparam int FRAME_MIN = 2047;
	localparam int FRAME_MAX = 2049;
	logic bclk_q;
	logic seen_q;
	logic rx_last_q;
	logic tx_last_q;
	logic rx_seen_q;
	logic tx_seen_q;
	logic [3:0] age_q;
	logic [3:0] hi_q;
	logic [11:0] gap_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Ages since bclk rise and fsync rise, fsync width
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bclk_q <= 1'b0;
			age_q <= 4'h0;
			hi_q <= 4'h0;
			gap_q <= 12'h0;
			seen_q <= 1'b0;
		end
		else
		begin
			bclk_q <= bclk;
			age_q <= (bclk && !bclk_q) ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
			hi_q <= fsync ? ((hi_q == 4'hf) ? hi_q : hi_q + 4'h1) : 4'h0;
			gap_q <= $rose(fsync) ? 12'h1 : ((gap_q == 12'hfff) ? gap_q : gap_q + 12'h1);
			seen_q <= seen_q | $rose(fsync);
		end
	end
	// Half seen at the previous block event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_seen_q <= 1'b0;
			tx_seen_q <= 1'b0;
			rx_last_q <= 1'b0;
			tx_last_q <= 1'b0;
		end
		else
		begin
			rx_seen_q <= rx_seen_q | rx_block;
			tx_seen_q <= tx_seen_q | tx_block;
			rx_last_q <= rx_block ? rx_block_half : rx_last_q;
			tx_last_q <= tx_block ? tx_block_half : tx_last_q;
		end
	end
	sequence fs_rise;
		$rose(fsync) ##0 seen_q;
	endsequence
	sequence fs_fall;
		$fell(fsync);
	endsequence
	fsync_width_a: assert property (fs_fall |-> hi_q inside {[7:9]})
		else $error("frame sync not one bit long");
	frame_len_a: assert property (fs_rise |-> gap_q inside {[FRAME_MIN:FRAME_MAX]})
		else $error("frame not 256 bits long");
	port_drive_a: assert property (($changed(rout_line) || $changed(sout_line)
		|| $changed(fsync)) |-> age_q <= 4'h5)
		else $error("port output moved off the drive edge");
	framer_drive_a: assert property (($changed(rx_line) || $changed(sx_line))
		|-> age_q <= 4'h6)
		else $error("framer output moved off the drive edge");
	rx_pulse_a: assert property (rx_block |=> !rx_block)
		else $error("receive block event longer than one cycle");
	tx_pulse_a: assert property (tx_block |=> !tx_block)
		else $error("transmit block event longer than one cycle");
	rx_halves_a: assert property (rx_block && rx_seen_q |-> rx_block_half != rx_last_q)
		else $error("receive halves did not alternate");
	tx_halves_a: assert property (tx_block && tx_seen_q |-> tx_block_half != tx_last_q)
		else $error("transmit halves did not alternate");
	rx_frame_a: assert property (rx_block |-> seen_q && gap_q <= 12'd16)
		else $error("receive block event away from frame boundary");
	tx_frame_a: assert property (tx_block |-> seen_q && gap_q <= 12'd16)
		else $error("transmit block event away from frame boundary");
endmodule : tdm_link_props

// *** verif/tdm_pcm_backplane_port_test.sv ***
// Testbench joining the TDM port and the framer pair
`timescale 1ns/1ps
module tdm_pcm_backplane_port_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, rx_block, rx_block_half, tx_block, tx_block_half;
	logic t1_mode = 1'b0;
	logic line_err = 1'b0;
	logic irq_en = 1'b0;
	logic [7:0] rin_byte = 8'h05;
	logic [7:0] sin_byte = 8'hbf;
	logic take, out_valid, irq, err;
	logic [4:0] take_slot, out_slot;
	logic [7:0] rout_byte, sout_byte;
	logic [31:0] rd;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	tdm_link_if lk();
	serial_tdm_port serial_tdm_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(lk), .rx_block(rx_block),
		.rx_block_half(rx_block_half), .tx_block(tx_block), .tx_block_half(tx_block_half));
	framer_pair_end framer_pair_end_inst (.pclk(pclk), .presetn(presetn), .link(lk),
		.t1_mode(t1_mode), .rin_byte(rin_byte), .sin_byte(sin_byte), .take(take),
		.take_slot(take_slot), .rout_byte(rout_byte), .sout_byte(sout_byte),
		.out_valid(out_valid), .out_slot(out_slot), .line_err(line_err), .irq_en(irq_en),
		.irq(irq));
	tdm_link_props tdm_link_props_inst (.pclk(pclk), .presetn(presetn), .bclk(lk.bclk),
		.fsync(lk.fsync), .rx_line(lk.rx_line), .sx_line(lk.sx_line),
		.rout_line(lk.rout_line), .sout_line(lk.sout_line), .rx_block(rx_block),
		.rx_block_half(rx_block_half), .tx_block(tx_block), .tx_block_half(tx_block_half));
	always #20 pclk = ~pclk;
	// Free-running backplane clock, unrelated in phase
	initial
	begin
		lk.bclk = 1'b0;
		#7;
		forever #160 lk.bclk = ~lk.bclk;
	end
	function automatic logic [7:0] rpat(input logic [4:0] s);
		rpat = {s, 3'h5};
	endfunction : rpat
	function automatic logic [7:0] spat(input logic [4:0] s);
		spat = ~{3'h2, s};
	endfunction : spat
	function automatic logic [17:0] ent(input logic [17:0] b, input logic h,
		input logic [4:0] s, input logic ln);
		ent = b + 18'({h, 6'h0, s, ln, 2'b00});
	endfunction : ent
	// Line bytes for the slot after the one just taken
	always @(posedge pclk)
	begin
		if (take)
		begin
			rin_byte <= rpat(take_slot + 5'd1);
			sin_byte <= spat(take_slot + 5'd1);
		end
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			$display("CHECK FAILED at %0t: run too long", $time);
			close_out();
		end
	end
	task close_out;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n < 50), 32'h1);
	endtask : apb
	task wait_blk(input logic tx_sel, input int cnt);
		int k;
		repeat (cnt)
		begin
			k = 0;
			do
			begin
				@(posedge pclk);
				k++;
			end
			while ((tx_sel ? tx_block : rx_block) !== 1'b1 && k < 5000);
			chk(32'(k < 5000), 32'h1);
		end
	endtask : wait_blk
	task t_regs;
		apb(1'b0, 18'h0, 32'h0);
		chk(rd, 32'h20);
		apb(1'b0, 18'h4, 32'h0);
		chk(rd, 32'd40);
		apb(1'b1, 18'hc, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 18'h4, 32'h0);
		apb(1'b0, 18'h4, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 18'h8, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 18'h0, 32'h40);
		apb(1'b1, 18'h10000, 32'h0);
		apb(1'b0, 18'h10000, 32'h0);
		chk(rd, 32'hff);
		apb(1'b1, 18'h0, 32'hc0);
		apb(1'b1, 18'h10000, 32'h0);
		apb(1'b0, 18'h10000, 32'h0);
		chk(rd, 32'hd5);
		$display("Test regs done");
	endtask : t_regs
	task t_rx;
		logic h;
		logic [4:0] s;
		apb(1'b1, 18'h0, 32'h21);
		wait_blk(1'b0, 3);
		h = rx_block_half;
		for (int i = 0; i < 3; i++)
		begin
			s = (i == 2) ? 5'd31 : 5'(i);
			apb(1'b0, ent(18'h08000, h, s, 1'b0), 32'h0);
			chk({24'h0, rd[7:0]}, {24'h0, rpat(s)});
			apb(1'b0, ent(18'h08000, h, s, 1'b1), 32'h0);
			chk({24'h0, rd[7:0]}, {24'h0, spat(s)});
		end
		$display("Test receive done");
	endtask : t_rx
	task t_tx;
		int k;
		for (int h = 0; h < 2; h++)
		begin
			apb(1'b1, ent(18'h10000, h[0], 5'd3, 1'b0), 32'ha5);
			apb(1'b1, ent(18'h10000, h[0], 5'd3, 1'b1), 32'h3c);
		end
		wait_blk(1'b1, 2);
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (!(out_valid === 1'b1 && out_slot === 5'd3) && k < 3000);
		chk({24'h0, rout_byte}, 32'ha5);
		chk({24'h0, sout_byte}, 32'h3c);
		$display("Test transmit done");
	endtask : t_tx
	task t_t1;
		int n;
		int bad;
		n = 0;
		bad = 0;
		t1_mode <= 1'b1;
		apb(1'b1, 18'h0, 32'h23);
		wait_blk(1'b0, 2);
		repeat (2100)
		begin
			@(posedge pclk);
			n += int'(out_valid === 1'b1);
			bad += int'(out_valid === 1'b1 && out_slot >= 5'd24);
		end
		chk(32'(bad), 32'h0);
		chk(32'(n >= 24), 32'h1);
		t1_mode <= 1'b0;
		$display("Test mapped T1 done");
	endtask : t_t1
	task t_pass;
		int n;
		n = 0;
		apb(1'b1, 18'h0, 32'h121);
		wait_blk(1'b0, 4);
		apb(1'b0, 18'h8, 32'h0);
		chk({30'h0, rd[15], rd[13]}, {30'h0, ~rx_block_half, 1'b1});
		repeat (3000)
		begin
			@(posedge pclk);
			if (out_valid === 1'b1)
			begin
				n++;
				chk({24'h0, rout_byte}, {24'h0, rpat(out_slot)});
				chk({24'h0, sout_byte}, {24'h0, spat(out_slot)});
			end
		end
		chk(32'(n >= 32), 32'h1);
		$display("Test pass-through done");
	endtask : t_pass
	task t_irq;
		@(posedge pclk);
		line_err <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		irq_en <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		line_err <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		$display("Test interrupt done");
	endtask : t_irq
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_rx();
		t_tx();
		t_t1();
		t_pass();
		t_irq();
		close_out();
	end
endmodule : tdm_pcm_backplane_port_test
